// ### include/dsc_pkg.sv
// constants, types and register map for the dual stage cooler sequencer
`default_nettype none
package dsc_pkg;
    // time base
    localparam int CLK_HZ       = 20_000_000;
    localparam int MIN_S        = 60;                  // minute tick, seconds
    localparam int MIN_CYCLES   = MIN_S * CLK_HZ;      // cycles per minute
    localparam int BLINK_MS     = 500;                 // half period of blink
    localparam int BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
    localparam int CH2_EN_MIN   = 2 * 60;              // channel two start
    localparam int CYCLE_MIN    = 3 * 60;              // gas routing period
    localparam int PWR_LOSS_MIN = 30;                  // retained state limit
    localparam int PRE_W        = 31;
    localparam int MIN_W        = 16;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ISTAT  = 8'h08;
    localparam logic [7:0] ADDR_IMASK  = 8'h0C;
    localparam logic [7:0] ADDR_MINUTE = 8'h10;

    // control and status field positions
    localparam int CTRL_RESTART = 0;
    localparam int STS_STATE    = 0;   // 4 bits
    localparam int STS_ROUTE    = 4;
    localparam int STS_CH2_EN   = 5;
    localparam int STS_VALID    = 6;
    localparam int STS_SELECT   = 7;
    localparam int STS_MAINS    = 8;
    localparam int STS_ALARM    = 9;

    // interrupt bits
    localparam int IRQ_CH1_READY = 0;
    localparam int IRQ_CH2_START = 1;
    localparam int IRQ_CHANGE    = 2;
    localparam int IRQ_PWR_FAIL  = 3;
    localparam int IRQ_PWR_BACK  = 4;
    localparam int IRQ_W         = 5;

    typedef enum logic [3:0] {
        ST_PRECOOL = 4'h1,
        ST_COOL1   = 4'h2,
        ST_RUN     = 4'h4,
        ST_PWRFAIL = 4'h8
    } dsc_state_e;

    // temperature threshold inputs
    typedef struct packed {
        logic precool_ok;    // pre-cooling stage at +4 C
        logic ch1_sub_zero;
        logic ch1_sub_m25;
        logic ch2_sub_zero;
        logic ch2_sub_m25;
    } dsc_sense_s;

    // indicator outputs
    typedef struct packed {
        logic ch1_warm_led;
        logic ch2_warm_led;
        logic ch1_cooling_on_led;
        logic ch2_cooling_on_led;
        logic ch1_ready_led;
        logic ch2_ready_led;
        logic all_ok_led;
        logic timing_cycle_led;
        logic ch2_selected_led;
    } dsc_led_s;

    typedef struct packed {
        dsc_state_e       state;
        dsc_state_e       saved;
        logic             valid;
        logic             route_ch2;
        logic             ch2_en;
        logic [PRE_W-1:0] pre_cnt;
        logic [PRE_W-1:0] blink_cnt;
        logic             blink;
        logic [MIN_W-1:0] run_min;
        logic [MIN_W-1:0] out_min;
        logic [IRQ_W-1:0] istat;
        logic [IRQ_W-1:0] imask;
        dsc_led_s         leds;
        logic             alarm;
        logic             ch1_cool;
        logic             ch2_cool;
        logic [31:0]      prdata;
    } dsc_st_s;
endpackage : dsc_pkg
`default_nettype wire

// ### verilog/dsc_sequencer.sv
// dual stage cooler sequencer with apb status and interrupt registers
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none
module dsc_sequencer
    import dsc_pkg::*;
#(
    parameter int MIN_TICK_CYCLES = MIN_CYCLES,
    parameter int BLINK_TICKS     = BLINK_CYCLES,
    parameter int CH2_START_MIN   = CH2_EN_MIN,
    parameter int ROUTE_MIN       = CYCLE_MIN,
    parameter int LOSS_LIMIT_MIN  = PWR_LOSS_MIN
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // plant sensing
    input  wire dsc_sense_s  sense,
    input  wire logic        mains_ok,
    input  wire logic        test_operation_selector,
    // plant control
    output dsc_led_s         leds,
    output logic             alarm_contact,
    output logic             ch1_cool_en,
    output logic             ch2_cool_en,
    output logic             gas_route_ch2,
    output logic             irq
);

    dsc_st_s q;
    dsc_st_s d;

    logic             setup;
    logic             wr;
    logic             mapped;
    logic             min_tick;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [31:0]      rd;

    // bus phase decode
    assign setup = psel && !penable;
    assign wr    = psel && penable && pwrite;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_ISTAT) || (paddr == ADDR_IMASK) ||
                    (paddr == ADDR_MINUTE);

    // zero-wait slave: read data is captured in setup, error on unmapped
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        d        = q;
        ev       = '0;
        clr      = '0;
        rd       = '0;
        min_tick = 1'b0;

        // free-running minute tick, drives every hour-scale count
        if (q.pre_cnt == PRE_W'(MIN_TICK_CYCLES - 1)) begin
            d.pre_cnt = '0;
            min_tick  = 1'b1;
        end else begin
            d.pre_cnt = q.pre_cnt + PRE_W'(1);
        end

        // blink enable for the timing indicator
        if (q.blink_cnt == PRE_W'(BLINK_TICKS - 1)) begin
            d.blink_cnt = '0;
            d.blink     = !q.blink;
        end else begin
            d.blink_cnt = q.blink_cnt + PRE_W'(1);
        end

        // sequence; mains loss overrides every state
        case (q.state)
            ST_PRECOOL: begin
                if (!mains_ok) begin
                    d.saved = q.state;
                    d.state = ST_PWRFAIL;
                    ev[IRQ_PWR_FAIL] = 1'b1;
                end else if (sense.precool_ok) begin
                    d.state = ST_COOL1;
                end
            end
            ST_COOL1: begin
                if (!mains_ok) begin
                    d.saved = q.state;
                    d.state = ST_PWRFAIL;
                    ev[IRQ_PWR_FAIL] = 1'b1;
                end else if (sense.ch1_sub_m25) begin
                    // cycle time counts from channel one ready
                    d.state   = ST_RUN;
                    d.run_min = '0;
                    ev[IRQ_CH1_READY] = 1'b1;
                end
            end
            ST_RUN: begin
                if (!mains_ok) begin
                    d.saved = q.state;
                    d.state = ST_PWRFAIL;
                    ev[IRQ_PWR_FAIL] = 1'b1;
                end else if (min_tick) begin
                    d.run_min = q.run_min + MIN_W'(1);
                    if (!q.ch2_en && d.run_min == MIN_W'(CH2_START_MIN)) begin
                        d.ch2_en = 1'b1;
                        ev[IRQ_CH2_START] = 1'b1;
                    end
                    // changeover every routing period, first one at 3 h
                    if (d.run_min == MIN_W'(ROUTE_MIN)) begin
                        d.route_ch2 = !q.route_ch2;
                        d.run_min   = '0;
                        ev[IRQ_CHANGE] = 1'b1;
                    end
                end
            end
            ST_PWRFAIL: begin
                // the run minute count and routing are held untouched meanwhile
                if (mains_ok) begin
                    ev[IRQ_PWR_BACK] = 1'b1;
                    d.out_min = '0;
                    if (q.valid) begin
                        d.state = q.saved;
                    end else begin
                        // stale state: behave as a new power-up
                        d.state     = ST_PRECOOL;
                        d.valid     = 1'b1;
                        d.route_ch2 = 1'b0;
                        d.ch2_en    = 1'b0;
                        d.run_min   = '0;
                    end
                end else if (min_tick && q.valid) begin
                    d.out_min = q.out_min + MIN_W'(1);
                    if (d.out_min >= MIN_W'(LOSS_LIMIT_MIN)) begin
                        d.valid = 1'b0;
                    end
                end
            end
            default: begin
                d.state = ST_PRECOOL;
            end
        endcase

        // software restart forces a fresh start-up; ignored without mains so the panel stays dark
        if (wr && paddr == ADDR_CTRL && pwdata[CTRL_RESTART] && mains_ok) begin
            d.state     = ST_PRECOOL;
            d.valid     = 1'b1;
            d.route_ch2 = 1'b0;
            d.ch2_en    = 1'b0;
            d.run_min   = '0;
            d.out_min   = '0;
        end

        // interrupt mask and write-one-to-clear status
        if (wr && paddr == ADDR_IMASK) begin
            d.imask = pwdata[IRQ_W-1:0];
        end
        if (wr && paddr == ADDR_ISTAT) begin
            clr = pwdata[IRQ_W-1:0];
        end
        // a new event beats a clear in the same cycle
        d.istat = (q.istat & ~clr) | ev;

        // indicators follow live thresholds while powered
        d.leds = '0;
        if (q.state != ST_PWRFAIL) begin
            d.leds.ch1_warm_led       = !sense.ch1_sub_zero;
            d.leds.ch2_warm_led       = !sense.ch2_sub_zero;
            d.leds.ch1_cooling_on_led = !q.route_ch2;
            d.leds.ch2_cooling_on_led = q.ch2_en;
            d.leds.ch2_selected_led   = q.route_ch2;
            d.leds.ch2_ready_led      = q.ch2_en && sense.ch2_sub_m25;
            if (q.state == ST_RUN) begin
                d.leds.ch1_ready_led    = sense.ch1_sub_m25;
                d.leds.all_ok_led       = 1'b1;
                d.leds.timing_cycle_led = q.blink;
            end
        end

        // alarm released only in the ready sequence; gas flows only then
        d.alarm    = (q.state != ST_RUN);
        d.ch1_cool = (q.state == ST_COOL1) || (q.state == ST_RUN);
        d.ch2_cool = q.ch2_en && (q.state == ST_RUN);

        // read data captured in the setup cycle
        if (paddr == ADDR_CTRL) begin
            rd = '0;
        end else if (paddr == ADDR_STATUS) begin
            rd[STS_STATE +: 4] = q.state;
            rd[STS_ROUTE]      = q.route_ch2;
            rd[STS_CH2_EN]     = q.ch2_en;
            rd[STS_VALID]      = q.valid;
            rd[STS_SELECT]     = test_operation_selector;
            rd[STS_MAINS]      = mains_ok;
            rd[STS_ALARM]      = q.alarm;
        end else if (paddr == ADDR_ISTAT) begin
            rd[IRQ_W-1:0] = q.istat;
        end else if (paddr == ADDR_IMASK) begin
            rd[IRQ_W-1:0] = q.imask;
        end else if (paddr == ADDR_MINUTE) begin
            rd[MIN_W-1:0] = q.run_min;
        end else begin
            rd = '0;
        end
        if (setup && !pwrite) begin
            d.prdata = rd;
        end
    end

    // single state register
    always_ff @(posedge clock) begin
        if (rst) begin
            q           <= '0;
            q.state     <= ST_PRECOOL;
            q.saved     <= ST_PRECOOL;
            q.valid     <= 1'b1;
            q.alarm     <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign prdata        = q.prdata;
    assign leds          = q.leds;
    assign alarm_contact = q.alarm;
    assign ch1_cool_en   = q.ch1_cool;
    assign ch2_cool_en   = q.ch2_cool;
    assign gas_route_ch2 = q.route_ch2;
    assign irq           = |(q.istat & q.imask);

endmodule : dsc_sequencer
`default_nettype wire

// ### sim/dsc_sequencer_asserts.sv
// port assertions for the cooler sequencer
`default_nettype none
module dsc_sequencer_asserts
    import dsc_pkg::*;
(
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // apb handshake
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // plant pins
    input wire dsc_sense_s sense,
    input wire logic       mains_ok,
    input wire dsc_led_s   leds,
    input wire logic       alarm_contact,
    input wire logic       ch1_cool_en,
    input wire logic       ch2_cool_en,
    input wire logic       gas_route_ch2
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // the contact releases gas exactly when all-ok is lit
    alarm_ok_a: assert property (alarm_contact != leds.all_ok_led) else $error("alarm and all ok agree");
    // a lit warm led needs a channel that was warm at the edge that loaded the led
    warm_one_a: assert property (leds.ch1_warm_led |-> !$past(sense.ch1_sub_zero))
        else $error("ch1 warm led while cold");
    warm_two_a: assert property (leds.ch2_warm_led |-> !$past(sense.ch2_sub_zero))
        else $error("ch2 warm led while cold");
    // three cycles without mains must leave everything dark
    mains_loss_a: assert property (!mains_ok [*3] |-> leds == 9'h000 && alarm_contact && !ch1_cool_en && !ch2_cool_en)
        else $error("outputs alive without mains");
    precool_gate_a: assert property ($rose(ch1_cool_en) |-> $past(sense.precool_ok, 2))
        else $error("ch1 enabled before precool");
    ch2_led_a: assert property ($rose(ch2_cool_en) |-> ##[0:1] leds.ch2_cooling_on_led)
        else $error("ch2 cooling led missing");
    ch2_ready_a: assert property (leds.ch2_ready_led |-> ch2_cool_en && $past(sense.ch2_sub_m25))
        else $error("ch2 ready without cold ch2");
    run_leds_a: assert property (leds.timing_cycle_led || leds.ch1_ready_led |-> !alarm_contact)
        else $error("run leds outside run");
    // an outage keeps the routing; a stale restart may clear it only once mains is back
    route_hold_a: assert property (!mains_ok |=> $stable(gas_route_ch2))
        else $error("route moved without mains");
    apb_ready_a: assert property (psel && penable |-> pready) else $error("access without ready");
    apb_err_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
endmodule : dsc_sequencer_asserts
bind dsc_sequencer dsc_sequencer_asserts u_dsc_sequencer_asserts (.clock, .rst, .psel, .penable, .pready,
    .pslverr, .sense, .mains_ok, .leds, .alarm_contact, .ch1_cool_en, .ch2_cool_en, .gas_route_ch2);
`default_nettype wire

// ### sim/dsc_gas_valve_model.sv
// sample gas pump or valve switched by the alarm contact
`default_nettype none
module dsc_gas_valve_model (
    // contact from the sequencer
    input wire logic alarm_contact,
    // gas flow downstream
    output var logic gas_flow
);
    timeunit 1ns;
    timeprecision 1ns;
    // an unknown contact blocks flow, failing safe like a real valve
    always_comb begin
        gas_flow = (alarm_contact === 1'b0);
    end
endmodule : dsc_gas_valve_model
`default_nettype wire

// ### sim/dsc_sequencer_test.sv
// directed test of the sequencer through apb and plant pins
`default_nettype none
module dsc_sequencer_test
    import dsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 10;
    localparam int CH2M = 2;
    localparam int RTM  = 3;
    localparam int LOSS = 2;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        mains_ok = 1'b1;
    logic        test_operation_selector = 1'b1; // held in operation position
    dsc_sense_s  sense = '0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, alarm_contact, ch1_cool_en, ch2_cool_en, gas_route_ch2, irq, gas_flow;
    logic        last_blink = 1'b0;
    dsc_led_s    leds;
    int          n_errors = 0, checked = 0, cyc = 0, blinks = 0, t0, t1, b0;

    dsc_sequencer #(.MIN_TICK_CYCLES(TICK), .BLINK_TICKS(4), .CH2_START_MIN(CH2M), .ROUTE_MIN(RTM),
        .LOSS_LIMIT_MIN(LOSS)) u_dsc_sequencer (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sense, .mains_ok, .test_operation_selector, .leds, .alarm_contact,
        .ch1_cool_en, .ch2_cool_en, .gas_route_ch2, .irq);
    dsc_gas_valve_model u_dsc_gas_valve_model (.alarm_contact, .gas_flow);

    // 50 ns clock
    initial begin
        forever #25 clock = ~clock;
    end

    // cycle stamp and blink edges for the timing checks
    always @(posedge clock) begin
        cyc <= cyc + 1;
        last_blink <= leds.timing_cycle_led;
        if (leds.timing_cycle_led !== last_blink)
            blinks <= blinks + 1;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // durations are bench counts, so plain ints are safe here
    task automatic chk_rng(input string what, input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    // one apb transfer; the request stands until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // watchdog well beyond the few hundred cycles of the sequence
    initial begin
        tick(3000);
        n_errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        stop_test();
    end

    // main sequence
    initial begin
        tick(6);
        rst <= 1'b0;
        tick(3);
        chk("power up leds", 3'b111, {leds.ch1_warm_led, leds.ch2_warm_led, leds.ch1_cooling_on_led});
        chk("ch1 early", 1'b0, ch1_cool_en);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h381, rd & 32'h3BF);
        xfer(1'b1, ADDR_IMASK, 32'h1F);
        xfer(1'b0, ADDR_IMASK, 32'h0);
        chk("imask", 32'h1F, rd);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        sense.precool_ok <= 1'b1;
        tick(3);
        chk("ch1 enable", 1'b1, ch1_cool_en);
        sense.ch1_sub_zero <= 1'b1;
        tick(3);
        chk("warm leds", 2'b01, {leds.ch1_warm_led, leds.ch2_warm_led});
        sense.ch1_sub_m25 <= 1'b1;
        t0 = cyc;
        tick(3);
        chk("ready leds", 3'b110, {leds.ch1_ready_led, leds.all_ok_led, alarm_contact});
        chk("gas flow", 1'b1, gas_flow);
        chk("irq up", 1'b1, irq);
        while (ch2_cool_en !== 1'b1) @(posedge clock);
        chk_rng("ch2 start", cyc - t0, (CH2M - 1) * TICK, CH2M * TICK + 4);
        sense.ch2_sub_zero <= 1'b1;
        sense.ch2_sub_m25 <= 1'b1;
        tick(3);
        chk("ch2 leds", 3'b101, {leds.ch2_cooling_on_led, leds.ch2_warm_led, leds.ch2_ready_led});
        while (gas_route_ch2 !== 1'b1) @(posedge clock);
        t1 = cyc;
        b0 = blinks;
        chk_rng("first change", t1 - t0, (RTM - 1) * TICK, RTM * TICK + 4);
        tick(2);
        chk("route leds", 2'b10, {leds.ch2_selected_led, leds.ch1_cooling_on_led});
        xfer(1'b0, ADDR_ISTAT, 32'h0);
        chk("istat", 32'h07, rd);
        xfer(1'b1, ADDR_ISTAT, 32'h1F);
        tick(1);
        chk("irq cleared", 1'b0, irq);
        while (gas_route_ch2 !== 1'b0) @(posedge clock);
        chk_rng("route period", cyc - t1, RTM * TICK, RTM * TICK);
        chk_rng("blink edges", blinks - b0, RTM * TICK / 4 - 1, RTM * TICK / 4 + 1);
        while (gas_route_ch2 !== 1'b1) @(posedge clock);
        // brief outage, shorter than one minute tick
        mains_ok <= 1'b0;
        tick(3);
        chk("leds off", 9'h000, leds);
        chk("gas cut", 2'b10, {alarm_contact, gas_flow});
        xfer(1'b0, ADDR_STATUS, 32'h0);
        mains_ok <= 1'b1;
        chk("status fail", 5'h18, rd[4:0]);
        tick(3);
        chk("resume", 4'b0111, {alarm_contact, gas_flow, gas_route_ch2, leds.all_ok_led});
        // long outage with the plant warming up
        mains_ok <= 1'b0;
        sense <= '0;
        tick(LOSS * TICK + 15);
        mains_ok <= 1'b1;
        tick(3);
        chk("fresh start", 3'b100, {alarm_contact, ch1_cool_en, gas_route_ch2});
        chk("fresh leds", 3'b111, {leds.ch1_warm_led, leds.ch2_warm_led, leds.ch1_cooling_on_led});
        xfer(1'b0, ADDR_ISTAT, 32'h0);
        chk("istat power", 32'h1C, rd);
        chk("irq power", 1'b1, irq);
        xfer(1'b1, ADDR_IMASK, 32'h0);
        tick(1);
        chk("irq masked", 1'b0, irq);
        sense <= '1;
        tick(5);
        chk("release cold", 2'b01, {alarm_contact, leds.ch1_ready_led});
        // minute count restarts at channel one ready, so at most one tick has passed
        xfer(1'b0, ADDR_MINUTE, 32'h0);
        chk_rng("minute count", rd, 0, 1);
        // software restart repeats start-up; the cold plant releases again two states later
        xfer(1'b1, ADDR_CTRL, 32'h1);
        tick(2);
        chk("restart alarm", 2'b10, {alarm_contact, leds.all_ok_led});
        tick(3);
        chk("restart release", 1'b0, alarm_contact);
        stop_test();
    end
endmodule : dsc_sequencer_test
`default_nettype wire
